// File: erb_pkg.sv
// Shared constants for the embedded RAM block.
package erb_pkg;
    localparam int          DATA_W     = 16;
    localparam int          ROW_AW     = 8;
    localparam int          ROWS       = 256;
    localparam int          MAX_AW     = 11;
    localparam int          LANE_W     = 3;
    localparam int          ORG_W      = 2;
    localparam int          TOTAL_BITS = 4096;
    localparam logic [1:0]  ORG_256X16 = 2'h0;
    localparam logic [1:0]  ORG_512X8  = 2'h1;
    localparam logic [1:0]  ORG_1KX4   = 2'h2;
    localparam logic [1:0]  ORG_2KX2   = 2'h3;
    localparam logic [15:0] DOUT_RST   = 16'h0000;
    localparam logic [10:0] ADDR_RST   = 11'h000;
endpackage : erb_pkg

// File: erb_mem.sv
// Storage array of the embedded RAM block with bit-masked writes and registered reads.
module erb_mem #(
    parameter int                  DEPTH = 256,
    parameter int                  WIDTH = 16,
    parameter int                  AW    = 8,
    parameter logic [DEPTH*WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk_i,
    input  wire logic             clr_n_i,
    input  wire logic             we_i,
    input  wire logic [WIDTH-1:0] wmask_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic             re_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // The array itself is never cleared, so a lookup pattern survives any clear.
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = INIT[i*WIDTH +: WIDTH];
        end
    end

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            for (int b = 0; b < WIDTH; b++) begin
                if (wmask_i[b]) begin
                    mem[waddr_i][b] <= wdata_i[b];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge clr_n_i) begin
        if (!clr_n_i) begin
            rdata_o <= '0;
        end else if (re_i) begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule : erb_mem

// File: erb_top.sv
// Configurable embedded RAM block: organisation, clocking scheme, optional path registers.
// Functional notes
// - Four organisations: 256x16, 512x8, 1024x4, 2048x2.
// - Total storage is 4096 bits, usable as RAM, ROM or FIFO storage.
// - Single-port or dual-port mode; write and read sections run at own rates.
// - Write and read sections each have a synchronous enable gating only themselves.
// - Alternative scheme: one enable for input registers, another for output register.
// - Data in, data out, write/read address and enables each registered or bypassed.
// - All registers clear asynchronously from local clear, global clear or reset.
// - Block makes its own write strobe from the write clock edge.
// - One write port and one read port per block; two blocks for two full ports.
// - Lookup mode: pattern preloaded at configuration, writes blocked, one-access lookup.
// - Blocks combine side by side for width, sharing address and control.
// - Blocks cascade in depth up to 2048 words without timing change.
module erb_top
    import erb_pkg::*;
#(
    parameter logic [TOTAL_BITS-1:0] INIT_PATTERN = '0
) (
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  clr_local_i,
    input  wire logic                  clr_global_i,
    input  wire logic [erb_pkg::ORG_W-1:0]  org_i,
    input  wire logic                  dual_mode_i,
    input  wire logic                  io_scheme_i,
    input  wire logic                  lookup_mode_i,
    input  wire logic                  reg_din_i,
    input  wire logic                  reg_dout_i,
    input  wire logic                  reg_waddr_i,
    input  wire logic                  reg_we_i,
    input  wire logic                  reg_raddr_i,
    input  wire logic                  reg_re_i,
    input  wire logic                  wr_ce_i,
    input  wire logic                  rd_ce_i,
    input  wire logic                  in_ce_i,
    input  wire logic                  out_ce_i,
    input  wire logic                  wsel_i,
    input  wire logic                  rsel_i,
    input  wire logic                  we_i,
    input  wire logic                  re_i,
    input  wire logic [erb_pkg::MAX_AW-1:0] waddr_i,
    input  wire logic [erb_pkg::MAX_AW-1:0] raddr_i,
    input  wire logic [erb_pkg::DATA_W-1:0] din_i,
    output logic      [erb_pkg::DATA_W-1:0] dout_o
);
    import erb_pkg::*;

    if (ROWS * DATA_W != TOTAL_BITS) begin : bad_geometry
        $error("Array geometry does not give the documented capacity.");
    end

    logic                clr_n;
    logic                wce;
    logic                rce;
    logic                oce;
    logic [MAX_AW-1:0]   waddr_q;
    logic [MAX_AW-1:0]   raddr_q;
    logic [DATA_W-1:0]   din_q;
    logic                we_q;
    logic                re_q;
    logic [MAX_AW-1:0]   waddr_p;
    logic [MAX_AW-1:0]   raddr_p;
    logic [DATA_W-1:0]   din_p;
    logic                we_p;
    logic                re_p;
    logic                mem_we;
    logic                mem_re;
    logic [DATA_W-1:0]   wmask;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic [DATA_W-1:0]   rslice;
    logic [LANE_W-1:0]   rlane;
    logic                rsel_q;
    logic [ROW_AW-1:0]   wrow;
    logic [ROW_AW-1:0]   rrow;
    logic [LANE_W-1:0]   wlane;
    logic [LANE_W-1:0]   rlane_now;

    // Any clear source empties every register at once; a gated clear is tolerated here
    // because the sources come from the same synchronous logic.
    assign clr_n = nrst_i & ~clr_local_i & ~clr_global_i;

    // Enable routing for the two clocking schemes.
    assign wce = io_scheme_i ? in_ce_i : wr_ce_i;
    assign rce = io_scheme_i ? in_ce_i : rd_ce_i;
    assign oce = io_scheme_i ? out_ce_i : rd_ce_i;

    function automatic logic [DATA_W-1:0] lane_mask(input logic [ORG_W-1:0] org);
        lane_mask = DATA_W'(16'hffff >> (DATA_W - (DATA_W >> org)));
    endfunction : lane_mask

    function automatic logic [ROW_AW-1:0] row_of(input logic [MAX_AW-1:0] a,
                                                input logic [ORG_W-1:0]  org);
        row_of = ROW_AW'(a >> org);
    endfunction : row_of

    function automatic logic [LANE_W-1:0] lane_of(input logic [MAX_AW-1:0] a,
                                                 input logic [ORG_W-1:0]  org);
        lane_of = LANE_W'(a) & LANE_W'((3'h1 << org) - 3'h1);
    endfunction : lane_of

    function automatic logic [4:0] bit_off(input logic [LANE_W-1:0] lane,
                                           input logic [ORG_W-1:0]  org);
        bit_off = 5'(lane) << (3'h4 - 3'(org));
    endfunction : bit_off

    // Write-section input registers.
    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            waddr_q <= ADDR_RST;
            din_q   <= DOUT_RST;
            we_q    <= 1'b0;
        end else if (wce) begin
            waddr_q <= waddr_i;
            din_q   <= din_i;
            we_q    <= we_i & wsel_i;
        end
    end

    // Read-section input registers.
    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            raddr_q <= ADDR_RST;
            re_q    <= 1'b0;
        end else if (rce) begin
            raddr_q <= raddr_i;
            re_q    <= re_i & rsel_i;
        end
    end

    assign waddr_p = reg_waddr_i ? waddr_q : waddr_i;
    assign din_p   = reg_din_i ? din_q : din_i;
    assign we_p    = reg_we_i ? we_q : (we_i & wsel_i);
    assign re_p    = reg_re_i ? re_q : (re_i & rsel_i);
    // A single-port block shares one address between writing and reading.
    assign raddr_p = !dual_mode_i ? waddr_p : (reg_raddr_i ? raddr_q : raddr_i);

    assign wrow      = row_of(waddr_p, org_i);
    assign wlane     = lane_of(waddr_p, org_i);
    assign rrow      = row_of(raddr_p, org_i);
    assign rlane_now = lane_of(raddr_p, org_i);

    // The strobe is formed here on the clock edge, so the user logic only meets setup.
    assign mem_we = we_p & wce & ~lookup_mode_i;
    assign mem_re = re_p & rce;
    assign wmask  = lane_mask(org_i) << bit_off(wlane, org_i);
    assign wdata  = (din_p & lane_mask(org_i)) << bit_off(wlane, org_i);

    erb_mem #(
        .DEPTH (ROWS),
        .WIDTH (DATA_W),
        .AW    (ROW_AW),
        .INIT  (INIT_PATTERN)
    ) u_mem (
        .clk_i   (clk_i),
        .clr_n_i (clr_n),
        .we_i    (mem_we),
        .wmask_i (wmask),
        .waddr_i (wrow),
        .wdata_i (wdata),
        .re_i    (mem_re),
        .raddr_i (rrow),
        .rdata_o (rdata)
    );

    // Lane and select follow the read so the slice matches the data it came with.
    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            rlane  <= '0;
            rsel_q <= 1'b0;
        end else if (rce) begin
            rlane  <= rlane_now;
            rsel_q <= mem_re;
        end
    end

    // A deselected block reads zero so that cascaded outputs can simply be ORed.
    assign rslice = rsel_q ? ((rdata >> bit_off(rlane, org_i)) & lane_mask(org_i))
                           : DOUT_RST;

    // Output stage: bypass follows the array each cycle, registered waits for its enable.
    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            dout_o <= DOUT_RST;
        end else if (!reg_dout_i || oce) begin
            dout_o <= rslice;
        end
    end

    sequence s_bypass_read;
        mem_re && rce && !reg_dout_i;
    endsequence

    sequence s_held_out;
        reg_dout_i && !oce;
    endsequence

    wr_strobe_a: assert property (@(posedge clk_i) disable iff (!clr_n)
        (we_i && wsel_i && wce && !reg_we_i && !lookup_mode_i) |-> mem_we)
        else $error("Qualified write produced no write strobe.");

    rom_nowrite_a: assert property (@(posedge clk_i) disable iff (!clr_n)
        lookup_mode_i |-> !mem_we)
        else $error("Lookup pattern was overwritten.");

    org_lane_a: assert property (@(posedge clk_i) disable iff (!clr_n)
        (org_i == ORG_256X16) |-> (wlane == 3'h0 && wrow == waddr_p[7:0]))
        else $error("Wide organisation used a lane.");

    deep_lane_a: assert property (@(posedge clk_i) disable iff (!clr_n)
        (org_i == ORG_2KX2) |-> (wmask == (16'h0003 << {waddr_p[2:0], 1'b0})))
        else $error("Two-bit lane mask misplaced.");

    single_port_a: assert property (@(posedge clk_i) disable iff (!clr_n)
        !dual_mode_i |-> raddr_p == waddr_p)
        else $error("Single-port read address differs from write address.");

    out_hold_a: assert property (@(posedge clk_i) disable iff (!clr_n)
        s_held_out ##1 !$fell(clr_n) |-> $stable(dout_o))
        else $error("Registered output moved without its enable.");

    read_path_a: assert property (@(posedge clk_i) disable iff (!clr_n)
        s_bypass_read ##1 (!reg_dout_i && !rce) |=> dout_o == $past(rslice))
        else $error("Bypassed output did not follow the array.");

    waddr_hold_a: assert property (@(posedge clk_i) disable iff (!clr_n)
        !wce |=> $stable(waddr_q) && $stable(we_q))
        else $error("Write section moved without its enable.");

    clear_out_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        clr_local_i || clr_global_i |-> dout_o == DOUT_RST && !re_q && !we_q)
        else $error("Clear did not empty the registers.");

    desel_zero_a: assert property (@(posedge clk_i) disable iff (!clr_n)
        !rsel_q |-> rslice == DOUT_RST)
        else $error("Deselected block drove read data.");
endmodule : erb_top

// File: erb_user_model.sv
// Model of the user logic that feeds requests, enables and clears to the RAM block.
module erb_user_model
    import erb_pkg::*;
(
    input  wire logic              clk_i,
    output logic                   we_o,
    output logic                   re_o,
    output logic                   wce_o,
    output logic                   rce_o,
    output logic                   ice_o,
    output logic                   wsel_o,
    output logic                   rsel_o,
    output logic                   clr_l_o,
    output logic                   clr_g_o,
    output logic [MAX_AW-1:0]      waddr_o,
    output logic [MAX_AW-1:0]      raddr_o,
    output logic [DATA_W-1:0]      din_o
);
    // Released lines carry the inverse so a stale value never passes for a request.
    initial begin
        {we_o, re_o, wce_o, rce_o, ice_o, wsel_o, rsel_o, clr_l_o, clr_g_o} = '0;
        {waddr_o, raddr_o, din_o} = '0;
    end
    task automatic put_write(input logic [MAX_AW-1:0] a, input logic [DATA_W-1:0] d,
                             input logic sel, input logic wce, input logic ice,
                             input int hold);
        @(posedge clk_i);
        {we_o, wsel_o, wce_o, ice_o} <= {1'b1, sel, wce, ice};
        waddr_o <= a;
        din_o <= d;
        // Registered paths need the enable held over the extra stage edges.
        repeat (hold) @(posedge clk_i);
        {we_o, wce_o, ice_o} <= 3'h0;
        waddr_o <= ~a;
        din_o <= ~d;
    endtask : put_write
    task automatic put_read(input logic [MAX_AW-1:0] a, input logic dual, input logic sel,
                            input int hold);
        @(posedge clk_i);
        {re_o, rce_o, rsel_o} <= {2'h3, sel};
        raddr_o <= dual ? a : ~a;
        waddr_o <= a;
        repeat (hold) @(posedge clk_i);
        {re_o, rce_o} <= 2'h0;
        raddr_o <= ~a;
        @(posedge clk_i);
    endtask : put_read
    task automatic put_clear(input logic glob);
        @(posedge clk_i);
        {clr_g_o, clr_l_o} <= {glob, !glob};
        @(posedge clk_i);
        {clr_g_o, clr_l_o} <= 2'h0;
    endtask : put_clear
endmodule : erb_user_model

// File: erb_top_tb.sv
// Self-checking bench for the embedded RAM block with random and corner-case traffic.
module erb_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import erb_pkg::*;
    localparam logic [TOTAL_BITS-1:0] PAT = {128{32'h5a3c_e187}};
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [ORG_W-1:0] org = '0;
    logic dual = 1'b1;
    logic io = 1'b0;
    logic lookup = 1'b0;
    logic regs = 1'b0;
    logic oce = 1'b1;
    logic [TOTAL_BITS-1:0] shadow = PAT;
    int seed = 13;
    int hold = 1;
    int bad_count = 0;
    int compares = 0;
    wire logic we, re, wce, rce, ice, wsel, rsel, clr_l, clr_g;
    wire logic [MAX_AW-1:0] waddr, raddr;
    wire logic [DATA_W-1:0] din, dout;
    always #4 clk_i = ~clk_i;
    erb_user_model u_user (.clk_i(clk_i), .we_o(we), .re_o(re), .wce_o(wce), .rce_o(rce),
        .ice_o(ice), .wsel_o(wsel), .rsel_o(rsel), .clr_l_o(clr_l), .clr_g_o(clr_g),
        .waddr_o(waddr), .raddr_o(raddr), .din_o(din));
    erb_top #(.INIT_PATTERN(PAT)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .clr_local_i(clr_l),
        .clr_global_i(clr_g), .org_i(org), .dual_mode_i(dual), .io_scheme_i(io),
        .lookup_mode_i(lookup), .reg_din_i(regs), .reg_dout_i(regs), .reg_waddr_i(regs),
        .reg_we_i(regs), .reg_raddr_i(regs), .reg_re_i(regs), .wr_ce_i(wce), .rd_ce_i(rce),
        .in_ce_i(ice), .out_ce_i(oce), .wsel_i(wsel), .rsel_i(rsel), .we_i(we), .re_i(re),
        .waddr_i(waddr), .raddr_i(raddr), .din_i(din), .dout_o(dout));
    function automatic logic [DATA_W-1:0] exp_word(input int a);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int b = 0; b < (DATA_W >> org); b++) r[b] = shadow[a * (DATA_W >> org) + b];
        return r;
    endfunction : exp_word
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic do_write(input int a, input logic [DATA_W-1:0] d, input logic sel,
                            input logic wce_v, input logic ice_v);
        u_user.put_write(a[MAX_AW-1:0], d, sel, wce_v, ice_v, hold);
        if (sel && (io ? ice_v : wce_v) && !lookup) begin
            for (int b = 0; b < (DATA_W >> org); b++) shadow[a * (DATA_W >> org) + b] = d[b];
        end
    endtask : do_write
    task automatic do_read(input int a, input logic sel);
        u_user.put_read(a[MAX_AW-1:0], dual, sel, hold);
        #1;
        chk(dout, sel ? exp_word(a) : DOUT_RST);
    endtask : do_read
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test
    task automatic give_verdict();
        $display("counts: compares=%0d mismatches=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        give_verdict();
    end
    initial begin
        int a;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        #1 chk(dout, DOUT_RST);
        end_test("reset");
        for (int o = 0; o < 4; o++) begin
            @(posedge clk_i) org <= o[ORG_W-1:0];
            do_read((256 << o) - 1, 1'b1);
            do_write((256 << o) - 1, 16'hffff, 1'b1, 1'b1, 1'b0);
            do_read((256 << o) - 1, 1'b1);
            repeat (12) begin
                a = $unsigned($random(seed)) % (256 << o);
                do_write(a, $random(seed), 1'b1, 1'b1, 1'b0);
                do_read(a, 1'b1);
            end
            end_test("organisation");
        end
        @(posedge clk_i) org <= ORG_256X16;
        do_write(5, 16'h1234, 1'b0, 1'b1, 1'b0);
        do_write(5, 16'h4321, 1'b1, 1'b0, 1'b0);
        do_read(5, 1'b1);
        do_read(5, 1'b0);
        @(posedge clk_i) dual <= 1'b0;
        do_write(7, 16'h0ff0, 1'b1, 1'b1, 1'b0);
        do_read(7, 1'b1);
        @(posedge clk_i) {dual, io} <= 2'h3;
        do_write(9, 16'hbeef, 1'b1, 1'b0, 1'b1);
        @(posedge clk_i) io <= 1'b0;
        do_read(9, 1'b1);
        @(posedge clk_i) lookup <= 1'b1;
        do_write(3, 16'h7777, 1'b1, 1'b1, 1'b0);
        do_read(3, 1'b1);
        end_test("enables");
        do_read(9, 1'b1);
        u_user.put_clear(1'b0);
        #1 chk(dout, DOUT_RST);
        do_read(9, 1'b1);
        u_user.put_clear(1'b1);
        #1 chk(dout, DOUT_RST);
        end_test("clears");
        @(posedge clk_i) {lookup, regs} <= 2'h1;
        hold = 3;
        repeat (8) begin
            a = $unsigned($random(seed)) % 256;
            do_write(a, $random(seed), 1'b1, 1'b1, 1'b0);
            do_read(a, 1'b1);
        end
        end_test("registered");
        give_verdict();
    end
endmodule : erb_top_tb
